// File: trace_mem_pkg.sv
`default_nettype none
package trace_mem_pkg;
  localparam int CLK_HZ      = 125_000_000;
  localparam int REFRESH_HZ  = 50;
  localparam int N_PTS       = 1001;
  localparam int LAST_PT     = 1000;
  localparam int PT_W        = 10;
  localparam int AMP_W       = 10;
  localparam int SMP_W       = 12;
  localparam int TOP_LINE    = 1000;
  localparam int OVR_UNITS   = 23;
  localparam int Y_MAX       = TOP_LINE + OVR_UNITS;
  localparam int DIVS        = 10;
  localparam int GRAT_LAST   = 2 * (DIVS + 1) - 1;
  localparam int FIFO_DEPTH  = 16;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;

  localparam logic [PT_W-1:0] DIV_UNITS = 10'h064;

  localparam logic [ADDR_W-1:0] REG_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PACE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PSEL = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_PDAT = 8'h10;

  localparam int MODE_A_LSB   = 0;
  localparam int MODE_B_LSB   = 2;
  localparam int PSEL_TRC_BIT = 16;
  localparam int STAT_FULL    = 1;
  localparam int STAT_RF_LSB  = 2;
  localparam int STAT_WA_LSB  = 16;

  localparam logic [DATA_W-1:0] PACE_RST = 32'h0000_09c0;

  typedef enum logic [1:0] {
    MODE_CLW   = 2'b00,
    MODE_PEAK  = 2'b01,
    MODE_VIEW  = 2'b10,
    MODE_BLANK = 2'b11
  } trace_mode_type;

  localparam trace_mode_type MODE_A_RST = MODE_CLW;
  localparam trace_mode_type MODE_B_RST = MODE_BLANK;

  typedef enum logic [1:0] {
    RF_IDLE  = 2'b00,
    RF_TRC_A = 2'b01,
    RF_TRC_B = 2'b10,
    RF_GRAT  = 2'b11
  } rf_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_type;

  typedef struct packed {
    logic            kind_grat;
    logic            trace_b;
    logic            bright;
    logic [PT_W-1:0] x;
    logic [PT_W-1:0] y;
    logic [PT_W-1:0] x_end;
    logic [PT_W-1:0] y_end;
  } disp_vec_type;
endpackage
`default_nettype wire

// File: trace_memory_modes.sv
`default_nettype none

module sample_fifo #(
  parameter int W = 12,
  parameter int D = 16
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] buf_q [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         push;
  logic         pop;

  assign o_valid = wp_q != rp_q;
  assign o_ready = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = buf_q[rp_q[AW-1:0]];

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_q <= '0;
    end else if (push) begin
      wp_q <= wp_q + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rp_q <= '0;
    end else if (pop) begin
      rp_q <= rp_q + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      buf_q[wp_q[AW-1:0]] <= i_data;
    end
  end
endmodule

module trace_memory_modes #(
  parameter int unsigned REFRESH_CYC =
    trace_mem_pkg::CLK_HZ / trace_mem_pkg::REFRESH_HZ,
  parameter int FIFO_DEPTH = trace_mem_pkg::FIFO_DEPTH
) (
  input  wire logic                                i_core_clk,
  input  wire logic                                i_rstn,
  input  wire trace_mem_pkg::reg_req_type          i_reg,
  output logic [trace_mem_pkg::DATA_W-1:0]         o_reg_rdata,
  input  wire logic                                i_smp_valid,
  input  wire logic [trace_mem_pkg::SMP_W-1:0]     i_smp_data,
  output logic                                     o_smp_ready,
  output logic                                     o_disp_valid,
  output trace_mem_pkg::disp_vec_type              o_disp
);
  import trace_mem_pkg::*;

  localparam logic [PT_W-1:0]  LAST_U  = PT_W'(LAST_PT);
  localparam logic [PT_W-1:0]  GLAST_U = PT_W'(GRAT_LAST);
  localparam logic [PT_W-1:0]  TOP_U   = PT_W'(TOP_LINE);
  localparam logic [31:0]      FR_LAST = 32'(REFRESH_CYC - 1);

  function automatic logic is_write(input trace_mode_type m);
    return (m == MODE_CLW) || (m == MODE_PEAK);
  endfunction

  function automatic logic is_shown(input trace_mode_type m);
    return m != MODE_BLANK;
  endfunction

  function automatic logic [AMP_W-1:0] clamp_amp(input logic [SMP_W-1:0] s);
    if (s > SMP_W'(Y_MAX)) begin
      return AMP_W'(Y_MAX);
    end
    return s[AMP_W-1:0];
  endfunction

  trace_mode_type    mode_q  [2];
  trace_mode_type    new_mode[2];
  logic [AMP_W-1:0]  mem_q   [2][N_PTS];
  logic [AMP_W-1:0]  cur_val [2];
  logic [AMP_W-1:0]  upd_val [2];
  logic [1:0]        clr;
  logic [1:0]        wr_en;
  logic              mode_wr;
  logic [DATA_W-1:0] pace_q;
  logic [DATA_W-1:0] pace_cnt_q;
  logic              pace_tick;
  logic              fifo_valid;
  logic [SMP_W-1:0]  fifo_data;
  logic [AMP_W-1:0]  amp;
  logic              pop;
  logic              both_wr;
  logic              sel_b;
  logic              tgt_q;
  logic [PT_W-1:0]   wr_addr_q;
  logic [PT_W-1:0]   psel_addr_q;
  logic              psel_trc_q;
  logic [DATA_W-1:0] rdata_q;
  logic [31:0]       frame_q;
  logic              frame_tick;
  rf_state_type      rf_q;
  logic [PT_W-1:0]   rf_idx_q;
  logic [PT_W-1:0]   gk;
  logic [PT_W-1:0]   gpos;
  disp_vec_type      disp_d;
  disp_vec_type      disp_q;
  logic              disp_valid_d;
  logic              disp_valid_q;

  // sample path
  sample_fifo #(
    .W (SMP_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_valid    (i_smp_valid),
    .o_ready    (o_smp_ready),
    .i_data     (i_smp_data),
    .o_valid    (fifo_valid),
    .i_ready    (pop),
    .o_data     (fifo_data)
  );

  assign mode_wr     = i_reg.wr && (i_reg.addr == REG_MODE);
  assign new_mode[0] = trace_mode_type'(i_reg.wdata[MODE_A_LSB +: 2]);
  assign new_mode[1] = trace_mode_type'(i_reg.wdata[MODE_B_LSB +: 2]);

  assign pace_tick = pace_cnt_q == '0;
  assign both_wr   = is_write(mode_q[0]) && is_write(mode_q[1]);
  assign sel_b     = both_wr ? tgt_q : is_write(mode_q[1]);
  assign pop       = fifo_valid && pace_tick &&
                     (is_write(mode_q[0]) || is_write(mode_q[1]));
  assign amp       = clamp_amp(fifo_data);

  // per-trace mode, clear and store logic
  for (genvar t = 0; t < 2; t++) begin : g_trc
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        mode_q[t] <= (t == 0) ? MODE_A_RST : MODE_B_RST;
      end else if (mode_wr) begin
        mode_q[t] <= new_mode[t];
      end
    end

    assign clr[t] = mode_wr && (new_mode[t] == MODE_CLW) &&
                    (mode_q[t] != MODE_CLW);
    assign wr_en[t] = pop && (sel_b == 1'(t)) && is_write(mode_q[t]);
    assign cur_val[t] = mem_q[t][wr_addr_q];
    assign upd_val[t] = (mode_q[t] == MODE_PEAK && amp <= cur_val[t]) ?
                        cur_val[t] : amp;

    for (genvar i = 0; i < N_PTS; i++) begin : g_pt
      always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          mem_q[t][i] <= '0;
        end else if (clr[t]) begin
          mem_q[t][i] <= '0;
        end else if (wr_en[t] && wr_addr_q == PT_W'(i)) begin
          mem_q[t][i] <= upd_val[t];
        end
      end
    end
  end

  // sweep pacing
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pace_q <= PACE_RST;
    end else if (i_reg.wr && i_reg.addr == REG_PACE) begin
      pace_q <= i_reg.wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pace_cnt_q <= PACE_RST;
    end else if (pace_tick) begin
      pace_cnt_q <= pace_q;
    end else begin
      pace_cnt_q <= pace_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_addr_q <= '0;
    end else if (pop) begin
      wr_addr_q <= (wr_addr_q == LAST_U) ? '0 : wr_addr_q + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tgt_q <= 1'b0;
    end else if (pop && wr_addr_q == LAST_U && both_wr) begin
      tgt_q <= ~tgt_q;
    end
  end

  // register port
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      psel_addr_q <= '0;
      psel_trc_q  <= 1'b0;
    end else if (i_reg.wr && i_reg.addr == REG_PSEL) begin
      psel_addr_q <= i_reg.wdata[PT_W-1:0];
      psel_trc_q  <= i_reg.wdata[PSEL_TRC_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= '0;
    end else if (i_reg.rd) begin
      case (i_reg.addr)
        REG_MODE: begin
          rdata_q <= {28'h0, mode_q[1], mode_q[0]};
        end
        REG_PACE: begin
          rdata_q <= pace_q;
        end
        REG_STAT: begin
          rdata_q <= '0;
          rdata_q[0] <= tgt_q;
          rdata_q[STAT_FULL] <= ~o_smp_ready;
          rdata_q[STAT_RF_LSB +: 2] <= rf_q;
          rdata_q[STAT_WA_LSB +: PT_W] <= wr_addr_q;
        end
        REG_PSEL: begin
          rdata_q <= {15'h0, psel_trc_q, 6'h0, psel_addr_q};
        end
        REG_PDAT: begin
          rdata_q <= (psel_addr_q <= LAST_U) ?
                     {22'h0, mem_q[psel_trc_q][psel_addr_q]} : '0;
        end
        default: begin
          rdata_q <= '0;
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_reg_rdata = rdata_q;

  // refresh engine, own frame timer
  assign frame_tick = frame_q == FR_LAST;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      frame_q <= '0;
    end else begin
      frame_q <= frame_tick ? '0 : frame_q + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rf_q     <= RF_IDLE;
      rf_idx_q <= '0;
    end else begin
      case (rf_q)
        RF_IDLE: begin
          rf_idx_q <= '0;
          if (frame_tick) begin
            rf_q <= RF_TRC_A;
          end
        end
        RF_TRC_A: begin
          rf_idx_q <= (rf_idx_q == LAST_U) ? '0 : rf_idx_q + 1'b1;
          if (rf_idx_q == LAST_U) begin
            rf_q <= RF_TRC_B;
          end
        end
        RF_TRC_B: begin
          rf_idx_q <= (rf_idx_q == LAST_U) ? '0 : rf_idx_q + 1'b1;
          if (rf_idx_q == LAST_U) begin
            rf_q <= RF_GRAT;
          end
        end
        RF_GRAT: begin
          rf_idx_q <= (rf_idx_q == GLAST_U) ? '0 : rf_idx_q + 1'b1;
          if (rf_idx_q == GLAST_U) begin
            rf_q <= RF_IDLE;
          end
        end
        default: begin
          rf_q     <= RF_IDLE;
          rf_idx_q <= '0;
        end
      endcase
    end
  end

  // graticule lines: 0..10 vertical, 11..21 horizontal
  assign gk   = (rf_idx_q <= PT_W'(DIVS)) ? rf_idx_q
                                          : rf_idx_q - PT_W'(DIVS + 1);
  assign gpos = gk * DIV_UNITS;

  always_comb begin
    disp_d       = '0;
    disp_valid_d = 1'b0;
    case (rf_q)
      RF_TRC_A, RF_TRC_B: begin
        disp_valid_d   = is_shown(mode_q[rf_q == RF_TRC_B]);
        disp_d.trace_b = rf_q == RF_TRC_B;
        disp_d.bright  = rf_q == RF_TRC_A;
        disp_d.x       = rf_idx_q;
        disp_d.y       = mem_q[rf_q == RF_TRC_B][rf_idx_q];
        disp_d.x_end   = rf_idx_q;
        disp_d.y_end   = disp_d.y;
      end
      RF_GRAT: begin
        disp_valid_d     = 1'b1;
        disp_d.kind_grat = 1'b1;
        if (rf_idx_q <= PT_W'(DIVS)) begin
          disp_d.x     = gpos;
          disp_d.x_end = gpos;
          disp_d.y_end = TOP_U;
        end else begin
          disp_d.y     = gpos;
          disp_d.y_end = gpos;
          disp_d.x_end = LAST_U;
        end
      end
      default: begin
        disp_valid_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      disp_valid_q <= 1'b0;
      disp_q       <= '0;
    end else begin
      disp_valid_q <= disp_valid_d;
      disp_q       <= disp_d;
    end
  end

  assign o_disp_valid = disp_valid_q;
  assign o_disp       = disp_q;

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  addr_range_a: assert property (
    wr_addr_q <= LAST_U)
    else $error("write address beyond last point");

  addr_step_a: assert property (
    pop |=> wr_addr_q == (($past(wr_addr_q) == LAST_U) ? '0
                          : $past(wr_addr_q) + 1'b1))
    else $error("write address did not step by one");

  pace_gate_a: assert property (
    pace_tick |=> pace_cnt_q == $past(pace_q))
    else $error("sweep pace counter not reloaded");

  clear_zero_a: assert property (
    clr[0] |=> mem_q[0][0] == '0 && mem_q[0][LAST_PT] == '0 &&
               mode_q[0] == MODE_CLW)
    else $error("clear-write entry left data in trace A");

  peak_keep_a: assert property (
    wr_en[0] && !clr[0] && mode_q[0] == MODE_PEAK && amp <= cur_val[0]
    |=> mem_q[0][$past(wr_addr_q)] == $past(cur_val[0]))
    else $error("peak hold overwrote a larger point");

  peak_take_a: assert property (
    wr_en[0] && !clr[0] && mode_q[0] == MODE_PEAK && amp > cur_val[0]
    |=> mem_q[0][$past(wr_addr_q)] == $past(amp))
    else $error("peak hold missed a larger sample");

  store_hold_a: assert property (
    !is_write(mode_q[1]) && !clr[1] |=> $stable(mem_q[1][LAST_PT]))
    else $error("stored trace B changed");

  alt_swap_a: assert property (
    pop && wr_addr_q == LAST_U && both_wr |=> tgt_q != $past(tgt_q))
    else $error("sweeps did not alternate");

  clamp_top_a: assert property (
    pop && fifo_data > SMP_W'(Y_MAX) |-> amp == AMP_W'(Y_MAX))
    else $error("overrange sample not limited");

  view_draw_a: assert property (
    rf_q == RF_TRC_A && mode_q[0] == MODE_VIEW
    |=> o_disp_valid && !o_disp.trace_b && o_disp.x == $past(rf_idx_q))
    else $error("viewed trace A not drawn");

  blank_quiet_a: assert property (
    rf_q == RF_TRC_B && mode_q[1] == MODE_BLANK |=> !o_disp_valid)
    else $error("blanked trace B drawn");

  bright_a_a: assert property (
    o_disp_valid && !o_disp.kind_grat |-> o_disp.bright == !o_disp.trace_b)
    else $error("trace intensity wrong");

  frame_start_a: assert property (
    rf_q == RF_IDLE && frame_tick |=> rf_q == RF_TRC_A && rf_idx_q == '0)
    else $error("refresh frame did not start");

  grat_edge_a: assert property (
    rf_q == RF_GRAT && rf_idx_q == PT_W'(DIVS)
    |=> o_disp.kind_grat && o_disp.x == LAST_U && o_disp.y_end == TOP_U)
    else $error("right graticule edge wrong");

  peak_cov: cover property (
    wr_en[0] && mode_q[0] == MODE_PEAK && amp > cur_val[0]);
  alt_cov: cover property (pop && wr_addr_q == LAST_U && both_wr);
  full_cov: cover property (!o_smp_ready);
  grat_cov: cover property (rf_q == RF_GRAT && rf_idx_q == GLAST_U);
endmodule

`default_nettype wire

// File: trace_partner.sv
`default_nettype none
module trace_partner
  import trace_mem_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_smp_ready,
  output logic              o_smp_valid,
  output logic [SMP_W-1:0]  o_smp_data,
  input  wire logic         i_disp_valid,
  input  wire disp_vec_type i_disp,
  input  wire logic         i_clr,
  output int                o_a_cnt,
  output int                o_b_cnt,
  output int                o_grat_cnt,
  output int                o_bad_cnt,
  output logic [PT_W-1:0]   o_a_pt10
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_smp_valid = 1'b0;
    o_smp_data  = '0;
  end

  // last point driven past full scale to exercise the limit
  function automatic logic [SMP_W-1:0] smp_val(input int i, input int s);
    return (i == 1000) ? 12'hfff : 12'((i + s) % 1024);
  endfunction

  // one sample per point, held until taken; gives up after 200 idle cycles
  task automatic send(input int n, input int s, output int sent);
    int idle;
    sent = 0;
    idle = 0;
    @(posedge i_core_clk);
    o_smp_valid <= 1'b1;
    o_smp_data  <= smp_val(0, s);
    while (sent < n && idle < 200) begin
      @(posedge i_core_clk);
      if (i_smp_ready) begin
        sent++;
        idle = 0;
        if (sent < n) o_smp_data <= smp_val(sent, s);
      end else begin
        idle++;
      end
    end
    o_smp_valid <= 1'b0;
    // released data shows no stale value
    o_smp_data  <= ~o_smp_data;
  endtask

  // display side: tally records of each kind
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn || i_clr) begin
      o_a_cnt    <= 0;
      o_b_cnt    <= 0;
      o_grat_cnt <= 0;
      o_bad_cnt  <= 0;
      o_a_pt10   <= '0;
    end else if (i_disp_valid) begin
      if (!i_disp.kind_grat && !i_disp.trace_b && i_disp.x == 10'h00a) begin
        o_a_pt10 <= i_disp.y;
      end
      if (i_disp.kind_grat) o_grat_cnt <= o_grat_cnt + 1;
      else if (i_disp.trace_b) o_b_cnt <= o_b_cnt + 1;
      else o_a_cnt <= o_a_cnt + 1;
      if (!i_disp.kind_grat && i_disp.bright == i_disp.trace_b) begin
        o_bad_cnt <= o_bad_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: trace_memory_modes_tb.sv
`default_nettype none
module trace_memory_modes_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import trace_mem_pkg::*;
  localparam int unsigned RCYC = 3000;

  logic               i_core_clk;
  logic               i_rstn;
  reg_req_type        req;
  logic [DATA_W-1:0]  rdata;
  logic               smp_valid;
  logic [SMP_W-1:0]   smp_data;
  logic               smp_ready;
  logic               disp_valid;
  disp_vec_type       disp;
  logic               clr;
  logic [PT_W-1:0]    a_pt10;
  int                 a_cnt, b_cnt, grat_cnt, bad_cnt;
  int                 fail_count;
  int                 tests_run;
  int                 sent;
  logic [31:0]        v, a10, b10;

  trace_memory_modes #(.REFRESH_CYC(RCYC), .FIFO_DEPTH(16))
    i_trace_memory_modes (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_reg(req),
    .o_reg_rdata(rdata), .i_smp_valid(smp_valid), .i_smp_data(smp_data),
    .o_smp_ready(smp_ready), .o_disp_valid(disp_valid), .o_disp(disp));

  trace_partner i_trace_partner (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_smp_ready(smp_ready),
    .o_smp_valid(smp_valid), .o_smp_data(smp_data),
    .i_disp_valid(disp_valid), .i_disp(disp), .i_clr(clr),
    .o_a_cnt(a_cnt), .o_b_cnt(b_cnt), .o_grat_cnt(grat_cnt),
    .o_bad_cnt(bad_cnt), .o_a_pt10(a_pt10));

  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge i_core_clk);
    req.wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge i_core_clk);
    req.rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_pt(input logic trc, input int idx,
                       output logic [31:0] d);
    wr_reg(REG_PSEL, {15'h0000, trc, 6'h00, 10'(idx)});
    rd_reg(REG_PDAT, d);
  endtask

  task automatic chk_pt(input logic trc, input int idx, input int exp);
    logic [31:0] d;
    rd_pt(trc, idx, d);
    check("point", d, 32'(exp));
  endtask

  task automatic sweep(input int s);
    i_trace_partner.send(1001, s, sent);
    check("sweep_sent", 32'(sent), 32'h0000_03e9);
    repeat (40) @(posedge i_core_clk);
  endtask

  // a window of one refresh period holds exactly one frame's records
  task automatic frame(input int ea, input int eb);
    @(posedge i_core_clk);
    clr <= 1'b1;
    @(posedge i_core_clk);
    clr <= 1'b0;
    repeat (RCYC) @(posedge i_core_clk);
    #1;
    check("a_records", 32'(a_cnt), 32'(ea));
    check("b_records", 32'(b_cnt), 32'(eb));
    check("grat_records", 32'(grat_cnt), 32'h16);
    check("intensity", 32'(bad_cnt), 32'h0);
  endtask

  initial begin
    repeat (40000) @(posedge i_core_clk);
    fail_count++;
    end_sim();
  end

  initial begin
    i_rstn     = 1'b0;
    req        = '0;
    clr        = 1'b1;
    fail_count = 0;
    tests_run  = 0;
    repeat (20) @(posedge i_core_clk);
    check("ready_in_reset", 32'(smp_ready), 32'h1);
    i_rstn <= 1'b1;
    rd_reg(REG_MODE, v);
    check("mode_rst", v, {28'h0, MODE_B_RST, MODE_A_RST});
    rd_reg(REG_PACE, v);
    check("pace_rst", v, PACE_RST);
    @(posedge i_core_clk);
    #1;
    check("rdata_idle", rdata, 32'h0);
    rd_reg(REG_STAT, v);
    check("wr_addr_rst", 32'(v[25:16]), 32'h0);
    wr_reg(8'h20, 32'hffff_ffff);
    rd_reg(8'h20, v);
    check("unmapped", v, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr_reg(REG_MODE, 32'(m * 5));
      rd_reg(REG_MODE, v);
      check("mode_rw", v, 32'(m * 5));
    end
    wr_reg(REG_MODE, 32'h0000_000c);
    wr_reg(REG_PACE, 32'h0);
    // let the slot counter run down from its reset count
    repeat (2500) @(posedge i_core_clk);
    chk_pt(1'b0, 500, 0);
    sweep(0);
    chk_pt(1'b0, 0, 0);
    chk_pt(1'b0, 500, 500);
    chk_pt(1'b0, 1000, 1023);
    chk_pt(1'b0, 1001, 0);
    chk_pt(1'b1, 500, 0);
    rd_reg(REG_STAT, v);
    check("wr_addr_wrap", 32'(v[25:16]), 32'h0);
    wr_reg(REG_MODE, 32'h0000_000d);
    sweep(512);
    chk_pt(1'b0, 100, 612);
    chk_pt(1'b0, 700, 700);
    chk_pt(1'b0, 1000, 1023);
    wr_reg(REG_MODE, 32'h0);
    chk_pt(1'b0, 700, 0);
    sweep(3);
    sweep(7);
    rd_pt(1'b0, 10, a10);
    rd_pt(1'b1, 10, b10);
    check("alt_a", a10, 32'h0000_000d);
    check("alt_b", b10, 32'h0000_0011);
    wr_reg(REG_MODE, 32'h0000_000e);
    frame(1001, 0);
    check("drawn_point", 32'(a_pt10), 32'h0000_000d);
    wr_reg(REG_MODE, 32'h0000_000a);
    frame(1001, 1001);
    wr_reg(REG_PACE, 32'h0000_0063);
    frame(1001, 1001);
    i_trace_partner.send(20, 40, sent);
    check("fifo_accepted", 32'(sent), 32'h10);
    check("ready_full", 32'(smp_ready), 32'h0);
    rd_reg(REG_STAT, v);
    check("stat_full", 32'(v[STAT_FULL]), 32'h1);
    chk_pt(1'b0, 10, int'(a10));
    wr_reg(REG_MODE, 32'h0000_000b);
    frame(0, 1001);
    wr_reg(REG_MODE, 32'h0000_000a);
    chk_pt(1'b0, 10, int'(a10));
    chk_pt(1'b1, 10, int'(b10));
    end_sim();
  end
endmodule
`default_nettype wire
